// ==== logic/divider.sv ====
`timescale 1ns/1ps
module divider
    import sys_prot_pkg::*;
#(
    parameter int DIV = 4
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    output logic tick_o
);
    logic [15:0] count;
    // free counter, pulses once every DIV clocks while running
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            count <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            tick_o <= 1'b0;
        end
        else if (count == 16'(DIV - 1))
        begin
            count <= 16'h0000;
            tick_o <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tick_o <= 1'b0;
        end
    end
    chk_tick_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tick_o |=> !tick_o || DIV == 1)
        else $error("tick not one cycle");
endmodule // divider

// ==== logic/ref_match.sv ====
`timescale 1ns/1ps
module ref_match
    import sys_prot_pkg::*;
#(
    parameter int W = 64
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] count_i,
    input wire logic [W-1:0] ref_i,
    input wire logic armed_i,
    output logic hit_o
);
    logic [W-1:0] last;
    // one pulse per new equality; a counter parked on the value fires once
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            last <= '0;
            hit_o <= 1'b0;
        end
        else
        begin
            last <= count_i;
            hit_o <= armed_i && count_i == ref_i && last != count_i;
        end
    end
endmodule // ref_match

// ==== logic/sys_prot_pkg.sv ====
package sys_prot_pkg;
    // timing: one time-base tick every TB_DIV clocks, one slow tick every PIT_DIV
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PIT_MIN_NS = 200;
    localparam int PIT_DIV = (PIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TB_DIV = 4;
    // bus monitor limit in clocks
    localparam logic [7:0] BUS_MON_LIMIT_RST = 8'hFF;
    // watchdog reset state: longest period, enabled, reset on expiry
    localparam logic [15:0] WDOG_PERIOD_MAX = 16'hFFFF;
    localparam logic WDOG_EN_RST = 1'b1;
    localparam logic WDOG_RST_SEL_RST = 1'b1;
    // watchdog service keys, written in order
    localparam logic [15:0] WDOG_KEY1 = 16'h556C;
    localparam logic [15:0] WDOG_KEY2 = 16'hAA39;
    // internal space decode
    localparam int BLOCK_SHIFT = 22;
    localparam int BASE_W = 3;
    // identification, values arbitrary
    localparam logic [15:0] PART_NUM = 16'h0A5C;
    localparam logic [15:0] MASK_REV = 16'h0001;
    localparam int NUM_REFS = 4;
    localparam int TB_W = 64;
    localparam int DEC_W = 32;
    localparam int RTC_W = 45;
    // pin mux config width
    localparam int MUX_W = 8;
    typedef enum logic [1:0]
    {
        BM_IDLE = 2'b00,
        BM_WAIT = 2'b01,
        BM_ERR = 2'b11
    } bus_mon_state_t;
endpackage

// ==== logic/system_config_protection.sv ====
// Functional notes
// - bus monitor times acknowledge; raises error acknowledge past limit; can disable
// - watchdog expiry raises reset or nmi as protection control selects
// - after reset watchdog enabled, longest period, reset on expiry
// - protection control register accepts first write only until reset
// - periodic timer gives periodic interrupts, programmable, can be disabled
// - 64-bit time base up counter, four references, equality interrupts
// - matching reference sets its own status bit
// - 32-bit decrementer clocked with time base raises interrupt
// - 45-bit clock counter with alarm, clocked like periodic timer
// - each counter has a run-in-freeze setting
// - sources gathered onto one interrupt request line
// - read-only part number and mask revision output
// - irq/portc/clock pins from straps at power-on, then config register
// - other shared pins from config register with hard-reset word
// - data and address gpio chosen by config register alone
// - reset-config pin is config input at power-on, then programmed
// - internal map is one 4-Mbyte block among first eight
// - arbitration select picks internal or external arbiter
// - priority bit sets external request priority under internal arbitration
`timescale 1ns/1ps
module system_config_protection
    import sys_prot_pkg::*;
#(
    parameter int PIT_W = 16
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic por_i,
    input wire logic freeze_indicator_i,
    // bus monitor
    input wire logic bus_mon_en_i,
    input wire logic [7:0] bus_mon_limit_i,
    input wire logic xfer_start_i,
    input wire logic transfer_acknowledge_i,
    // protection control write
    input wire logic prot_wr_i,
    input wire logic prot_wdog_en_i,
    input wire logic prot_wdog_rst_sel_i,
    input wire logic [15:0] prot_wdog_period_i,
    input wire logic [4:0] prot_frz_run_i,
    input wire logic service_wr_i,
    input wire logic [15:0] service_data_i,
    // periodic timer
    input wire logic pit_en_i,
    input wire logic [PIT_W-1:0] pit_period_i,
    // time base
    input wire logic tb_ref_wr_i,
    input wire logic [1:0] tb_ref_sel_i,
    input wire logic [TB_W-1:0] tb_ref_data_i,
    input wire logic [NUM_REFS-1:0] tb_ref_mask_i,
    input wire logic [NUM_REFS-1:0] tb_status_clr_i,
    input wire logic dec_wr_i,
    input wire logic [DEC_W-1:0] dec_data_i,
    input wire logic [RTC_W-1:0] rtc_alarm_i,
    input wire logic rtc_alarm_en_i,
    input wire logic [3:0] ext_irq_i,
    // configuration
    input wire logic [MUX_W-1:0] module_configuration_reg_i,
    input wire logic [MUX_W-1:0] hard_reset_config_i,
    input wire logic [2:0] clock_mode_strap_i,
    input wire logic reset_config_input_i,
    input wire logic [BASE_W-1:0] internal_space_base_i,
    input wire logic external_arbitration_select_i,
    input wire logic arbitration_priority_i,
    input wire logic [31:0] addr_i,
    output logic transfer_error_acknowledge_o,
    output logic wdog_reset_o,
    output logic wdog_nmi_o,
    output logic irq_o,
    output logic [NUM_REFS-1:0] tb_status_o,
    output logic [TB_W-1:0] time_base_o,
    output logic [DEC_W-1:0] decrementer_o,
    output logic [RTC_W-1:0] rtc_o,
    output logic [31:0] part_id_o,
    output logic [MUX_W-1:0] shared_pin_sel_o,
    output logic [MUX_W-1:0] ctrl_pin_sel_o,
    output logic gpio_sel_o,
    output logic reset_config_input_func_o,
    output logic internal_hit_o,
    output logic internal_arbiter_o,
    output logic ext_req_high_o
);
    logic tb_tick;
    logic pit_tick;
    logic [NUM_REFS-1:0] ref_hit;
    logic [TB_W-1:0] ref_val [NUM_REFS];
    bus_mon_state_t bm_state;
    logic [7:0] bm_count;
    logic prot_locked;
    logic wdog_en;
    logic wdog_rst_sel;
    logic [15:0] wdog_period;
    logic [4:0] frz_run;
    logic [15:0] wdog_count;
    logic key1_seen;
    logic [PIT_W-1:0] pit_count;
    logic pit_irq;
    logic dec_irq;
    logic rtc_irq;
    logic rtc_hit;
    logic [2:0] strap_latch;
    logic reset_config_input_latch;
    logic por_d;

    // freeze gating: a 0 in frz_run stops that counter while frozen
    wire wdog_run = !freeze_indicator_i || frz_run[0];
    wire pit_run = !freeze_indicator_i || frz_run[1];
    wire tb_run = !freeze_indicator_i || frz_run[2];
    wire dec_run = !freeze_indicator_i || frz_run[3];
    wire rtc_run = !freeze_indicator_i || frz_run[4];

    divider #(.DIV(TB_DIV)) u_tb_div
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(1'b1),
        .tick_o(tb_tick)
    );
    divider #(.DIV(PIT_DIV)) u_pit_div
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(1'b1),
        .tick_o(pit_tick)
    );

    // bus monitor: count clocks from start until acknowledge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bm_state <= BM_IDLE;
            bm_count <= 8'h00;
            transfer_error_acknowledge_o <= 1'b0;
        end
        else
        begin
            transfer_error_acknowledge_o <= 1'b0;
            case (bm_state)
                BM_IDLE:
                begin
                    bm_count <= 8'h00;
                    if (xfer_start_i && bus_mon_en_i)
                        bm_state <= BM_WAIT;
                end
                BM_WAIT:
                begin
                    if (transfer_acknowledge_i || !bus_mon_en_i)
                        bm_state <= BM_IDLE;
                    else if (bm_count >= bus_mon_limit_i)
                    begin
                        bm_state <= BM_ERR;
                        transfer_error_acknowledge_o <= 1'b1;
                    end
                    else
                        bm_count <= bm_count + 8'h01;
                end
                BM_ERR: bm_state <= BM_IDLE;
                default: bm_state <= BM_IDLE;
            endcase
        end
    end

    // write-once protection control; reset values give the safe default
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prot_locked <= 1'b0;
            wdog_en <= WDOG_EN_RST;
            wdog_rst_sel <= WDOG_RST_SEL_RST;
            wdog_period <= WDOG_PERIOD_MAX;
            frz_run <= 5'h00;
        end
        else if (prot_wr_i && !prot_locked)
        begin
            prot_locked <= 1'b1;
            wdog_en <= prot_wdog_en_i;
            wdog_rst_sel <= prot_wdog_rst_sel_i;
            wdog_period <= prot_wdog_period_i;
            frz_run <= prot_frz_run_i;
        end
    end

    // watchdog: two-key service so a runaway loop cannot refresh it
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wdog_count <= WDOG_PERIOD_MAX;
            key1_seen <= 1'b0;
            wdog_reset_o <= 1'b0;
            wdog_nmi_o <= 1'b0;
        end
        else
        begin
            wdog_reset_o <= 1'b0;
            wdog_nmi_o <= 1'b0;
            if (service_wr_i && service_data_i == WDOG_KEY1)
                key1_seen <= 1'b1;
            else if (service_wr_i)
                key1_seen <= 1'b0;
            if (service_wr_i && service_data_i == WDOG_KEY2 && key1_seen)
                wdog_count <= wdog_period;
            else if (!wdog_en)
                wdog_count <= wdog_period;
            else if (tb_tick && wdog_run)
            begin
                if (wdog_count == 16'h0000)
                begin
                    wdog_count <= wdog_period;
                    wdog_reset_o <= wdog_rst_sel;
                    wdog_nmi_o <= !wdog_rst_sel;
                end
                else
                    wdog_count <= wdog_count - 16'h0001;
            end
        end
    end

    // periodic timer reloads from the period on reaching zero
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pit_count <= '0;
            pit_irq <= 1'b0;
        end
        else
        begin
            pit_irq <= 1'b0;
            if (!pit_en_i)
                pit_count <= pit_period_i;
            else if (pit_tick && pit_run)
            begin
                if (pit_count == '0)
                begin
                    pit_count <= pit_period_i;
                    pit_irq <= 1'b1;
                end
                else
                    pit_count <= pit_count - 1'b1;
            end
        end
    end

    // time base and its reference registers
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            time_base_o <= '0;
        else if (tb_tick && tb_run)
            time_base_o <= time_base_o + 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < NUM_REFS; i++)
                ref_val[i] <= '1;
        end
        else if (tb_ref_wr_i)
            ref_val[tb_ref_sel_i] <= tb_ref_data_i;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REFS; g++)
        begin : g_ref
            ref_match #(.W(TB_W)) u_ref
            (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .count_i(time_base_o),
                .ref_i(ref_val[g]),
                .armed_i(1'b1),
                .hit_o(ref_hit[g])
            );
            // sticky status, set wins over clear
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                    tb_status_o[g] <= 1'b0;
                else if (ref_hit[g])
                    tb_status_o[g] <= 1'b1;
                else if (tb_status_clr_i[g])
                    tb_status_o[g] <= 1'b0;
            end
        end
    endgenerate

    // decrementer shares the time-base tick
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            decrementer_o <= '1;
            dec_irq <= 1'b0;
        end
        else
        begin
            dec_irq <= 1'b0;
            if (dec_wr_i)
                decrementer_o <= dec_data_i;
            else if (tb_tick && dec_run)
            begin
                decrementer_o <= decrementer_o - 1'b1;
                dec_irq <= decrementer_o == '0;
            end
        end
    end

    // time-of-day counter on the periodic timer's clock
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rtc_o <= '0;
        else if (pit_tick && rtc_run)
            rtc_o <= rtc_o + 1'b1;
    end

    ref_match #(.W(RTC_W)) u_alarm
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .count_i(rtc_o),
        .ref_i(rtc_alarm_i),
        .armed_i(rtc_alarm_en_i),
        .hit_o(rtc_hit)
    );
    assign rtc_irq = rtc_hit;

    // funnel all maskable requests onto one line
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            irq_o <= pit_irq || dec_irq || rtc_irq || |ext_irq_i
                || |(tb_status_o & tb_ref_mask_i);
    end

    // straps are caught on the clock while power-on reset is asserted
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_latch <= 3'h0;
            reset_config_input_latch <= 1'b0;
            por_d <= 1'b0;
        end
        else
        begin
            por_d <= por_i;
            if (por_i)
            begin
                strap_latch <= clock_mode_strap_i;
                reset_config_input_latch <= reset_config_input_i;
            end
        end
    end

    // pin function, address decode and arbitration outputs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            part_id_o <= 32'h00000000;
            shared_pin_sel_o <= '0;
            ctrl_pin_sel_o <= '0;
            gpio_sel_o <= 1'b0;
            reset_config_input_func_o <= 1'b0;
            internal_hit_o <= 1'b0;
            internal_arbiter_o <= 1'b1;
            ext_req_high_o <= 1'b0;
        end
        else
        begin
            part_id_o <= {PART_NUM, MASK_REV};
            shared_pin_sel_o <= (por_i || por_d)
                ? {5'h00, strap_latch}
                : module_configuration_reg_i;
            ctrl_pin_sel_o <= module_configuration_reg_i
                ^ hard_reset_config_i;
            gpio_sel_o <= module_configuration_reg_i[MUX_W-1];
            reset_config_input_func_o <= por_i ? reset_config_input_latch
                : module_configuration_reg_i[MUX_W-2];
            internal_hit_o <= addr_i[31:BLOCK_SHIFT+BASE_W] == '0
                && addr_i[BLOCK_SHIFT+BASE_W-1:BLOCK_SHIFT]
                == internal_space_base_i;
            internal_arbiter_o <= !external_arbitration_select_i;
            ext_req_high_o <= !external_arbitration_select_i
                && arbitration_priority_i;
        end
    end

    chk_bm_error: assert property (@(posedge clk_i) disable iff (!rstn_i)
        transfer_error_acknowledge_o |-> $past(bm_state) == BM_WAIT
        && !$past(transfer_acknowledge_i))
        else $error("error ack without timeout");
    chk_wdog_excl: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(wdog_reset_o && wdog_nmi_o))
        else $error("watchdog reset and nmi together");
    chk_prot_lock: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(prot_locked) |-> $stable(wdog_period) && $stable(wdog_en))
        else $error("protection register rewritten");
    chk_status_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ref_hit[0] |=> tb_status_o[0])
        else $error("status bit not set");
    chk_tb_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tb_tick && tb_run |=> time_base_o == $past(time_base_o) + 1'b1)
        else $error("time base did not step");
    chk_freeze_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        freeze_indicator_i && !frz_run[4] |=> $stable(rtc_o))
        else $error("rtc ran in freeze");
    chk_irq_funnel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pit_irq || dec_irq |=> irq_o)
        else $error("irq not raised");
    chk_arb_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        external_arbitration_select_i |=> !internal_arbiter_o
        && !ext_req_high_o)
        else $error("arbiter select wrong");
    cov_timeout: cover property (@(posedge clk_i) transfer_error_acknowledge_o);
    cov_wdog_nmi: cover property (@(posedge clk_i) wdog_nmi_o);
    cov_ref_hit: cover property (@(posedge clk_i) |ref_hit);
endmodule // system_config_protection

// ==== tb/ext_bus_slave.sv ====
`timescale 1ns/1ps
module ext_bus_slave
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic xfer_start_i,
    input wire logic [7:0] ack_delay_i,
    output logic transfer_acknowledge_o
);
    logic [7:0] cnt;

    // answer ack_delay_i edges after a start; zero models a slave that hangs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt <= 8'h00;
            transfer_acknowledge_o <= 1'h0;
        end
        else
        begin
            transfer_acknowledge_o <= cnt == 8'h01;
            if (xfer_start_i)
                cnt <= ack_delay_i;
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
endmodule // ext_bus_slave

// ==== tb/system_config_protection_tb.sv ====
`timescale 1ns/1ps
module system_config_protection_tb
    import sys_prot_pkg::*;
;
    logic clk_i, rstn_i, por_i, freeze_indicator_i, bus_mon_en_i;
    logic xfer_start_i, transfer_acknowledge_i, prot_wr_i, prot_wdog_en_i;
    logic prot_wdog_rst_sel_i, service_wr_i, pit_en_i, tb_ref_wr_i, dec_wr_i;
    logic rtc_alarm_en_i, reset_config_input_i, external_arbitration_select_i;
    logic arbitration_priority_i;
    logic [7:0] bus_mon_limit_i, module_configuration_reg_i;
    logic [7:0] hard_reset_config_i, ack_delay;
    logic [15:0] prot_wdog_period_i, service_data_i, pit_period_i;
    logic [4:0] prot_frz_run_i;
    logic [1:0] tb_ref_sel_i;
    logic [TB_W-1:0] tb_ref_data_i, time_base_o, t0;
    logic [3:0] tb_ref_mask_i, tb_status_clr_i, ext_irq_i, tb_status_o;
    logic [DEC_W-1:0] dec_data_i, decrementer_o;
    logic [RTC_W-1:0] rtc_alarm_i, rtc_o;
    logic [2:0] clock_mode_strap_i, internal_space_base_i;
    logic [31:0] addr_i, part_id_o;
    logic transfer_error_acknowledge_o, wdog_reset_o, wdog_nmi_o, irq_o;
    logic gpio_sel_o, reset_config_input_func_o, internal_hit_o, internal_arbiter_o;
    logic ext_req_high_o;
    logic [MUX_W-1:0] shared_pin_sel_o, ctrl_pin_sel_o;
    int failures, n_compared, c_tea, c_irq, c_nmi, c_rst, n;

    typedef struct packed {
        logic [2:0] base;
        logic [31:0] addr;
        logic external_arbitration_select;
        logic arbitration_priority;
        logic [7:0] mcr;
        logic [7:0] hrcw;
        logic hit;
    } row_t;
    // decode edges: block ends, wrong block, bits above the map set
    localparam row_t ROWS [8] = '{
        '{3'h0, 32'h00000000, 1'h0, 1'h1, 8'h80, 8'h0F, 1'h1},
        '{3'h0, 32'h003FFFFC, 1'h1, 1'h0, 8'h00, 8'hF0, 1'h1},
        '{3'h0, 32'h00400000, 1'h0, 1'h0, 8'h7F, 8'h3C, 1'h0},
        '{3'h7, 32'h01C00010, 1'h1, 1'h1, 8'hA5, 8'h00, 1'h1},
        '{3'h7, 32'h03C00010, 1'h0, 1'h1, 8'h5A, 8'hFF, 1'h0},
        '{3'h3, 32'h00C00000, 1'h0, 1'h0, 8'hC3, 8'h81, 1'h1},
        '{3'h3, 32'h80C00000, 1'h1, 1'h0, 8'h3C, 8'h18, 1'h0},
        '{3'h5, 32'h01400000, 1'h0, 1'h1, 8'hFF, 8'h55, 1'h1}};

    system_config_protection #(.PIT_W(16)) DUT (.*);

    ext_bus_slave slave (.clk_i, .rstn_i, .xfer_start_i,
        .ack_delay_i(ack_delay), .transfer_acknowledge_o(transfer_acknowledge_i));

    // 20 MHz clock
    initial
    begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // outputs are sampled on the falling edge, clear of update races
    task automatic mid;
        @(negedge clk_i);
    endtask

    task automatic watch(input int k);
        {c_tea, c_irq, c_nmi, c_rst} = '0;
        repeat (k)
        begin
            mid;
            c_tea += int'(transfer_error_acknowledge_o === 1'h1);
            c_irq += int'(irq_o === 1'h1);
            c_nmi += int'(wdog_nmi_o === 1'h1);
            c_rst += int'(wdog_reset_o === 1'h1);
        end
    endtask

    task automatic do_reset;
        rstn_i <= 1'h0;
        step(2);
        mid;
        chk("dec_rst", {DEC_W{1'h1}}, decrementer_o);
        chk("arb_rst", 1'h1, internal_arbiter_o);
        step(1);
        rstn_i <= 1'h1;
        step(2);
        mid;
        chk("part_id", {PART_NUM, MASK_REV}, part_id_o);
    endtask

    task automatic bus_xfer(input logic en, input logic [7:0] dly, input logic e);
        step(1);
        bus_mon_en_i <= en;
        ack_delay <= dly;
        xfer_start_i <= 1'h1;
        step(1);
        xfer_start_i <= 1'h0;
        watch(20);
        chk("tea", e, 64'(c_tea));
    endtask

    task automatic summarize;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hang costs at most 30000 cycles
    initial
    begin
        #1500000;
        failures++;
        summarize();
    end

    initial
    begin
        {rstn_i, freeze_indicator_i, bus_mon_en_i, bus_mon_limit_i, xfer_start_i,
            prot_wr_i, prot_wdog_en_i, prot_wdog_rst_sel_i, prot_wdog_period_i,
            prot_frz_run_i, service_wr_i, service_data_i, pit_en_i,
            pit_period_i, tb_ref_wr_i, tb_ref_sel_i, tb_ref_data_i,
            tb_ref_mask_i, tb_status_clr_i, dec_wr_i, dec_data_i, rtc_alarm_i,
            rtc_alarm_en_i, ext_irq_i, module_configuration_reg_i,
            hard_reset_config_i, internal_space_base_i, addr_i, ack_delay,
            external_arbitration_select_i, arbitration_priority_i} = '0;
        por_i = 1'h1;
        clock_mode_strap_i = 3'h5;
        reset_config_input_i = 1'h1;
        do_reset();
        // pin functions frozen by straps during power-on, then follow config
        chk("rcfg_por", 1'h1, reset_config_input_func_o);
        step(1);
        module_configuration_reg_i <= 8'h83;
        step(3);
        mid;
        chk("shared_por", 8'h05, shared_pin_sel_o);
        chk("rcfg_por2", 1'h1, reset_config_input_func_o);
        step(1);
        por_i <= 1'h0;
        step(3);
        mid;
        chk("shared_run", 8'h83, shared_pin_sel_o);
        chk("rcfg_run", 1'h0, reset_config_input_func_o);
        foreach (ROWS[i])
        begin
            step(1);
            internal_space_base_i <= ROWS[i].base;
            addr_i <= ROWS[i].addr;
            external_arbitration_select_i <= ROWS[i].external_arbitration_select;
            arbitration_priority_i <= ROWS[i].arbitration_priority;
            module_configuration_reg_i <= ROWS[i].mcr;
            hard_reset_config_i <= ROWS[i].hrcw;
            step(2);
            mid;
            chk("hit", ROWS[i].hit, internal_hit_o);
            chk("arb", !ROWS[i].external_arbitration_select, internal_arbiter_o);
            if (!ROWS[i].external_arbitration_select)
            begin
                chk("prio", ROWS[i].arbitration_priority, ext_req_high_o);
            end
            chk("gpio", ROWS[i].mcr[7], gpio_sel_o);
            chk("ctrl", ROWS[i].mcr ^ ROWS[i].hrcw, ctrl_pin_sel_o);
            chk("shared", ROWS[i].mcr, shared_pin_sel_o);
            chk("rcfg", ROWS[i].mcr[6], reset_config_input_func_o);
        end
        // bus monitor: prompt, late-but-in-time, hung slave, disabled
        bus_mon_limit_i <= 8'h05;
        bus_xfer(1'h1, 8'h02, 1'h0);
        bus_xfer(1'h1, 8'h04, 1'h0);
        bus_xfer(1'h1, 8'h00, 1'h1);
        bus_xfer(1'h0, 8'h00, 1'h0);
        mid;
        t0 = time_base_o;
        step(40);
        mid;
        chk("tb_count", t0 + 64'hA, time_base_o);
        // each reference in turn; the last one is masked off
        for (int k = 0; k < NUM_REFS; k++)
        begin
            step(1);
            tb_ref_mask_i <= (k == 3) ? 4'h0 : 4'h1 << k;
            tb_ref_wr_i <= 1'h1;
            tb_ref_sel_i <= 2'(k);
            tb_ref_data_i <= time_base_o + 64'h8;
            step(1);
            tb_ref_wr_i <= 1'h0;
            n = 0;
            while (tb_status_o[k] !== 1'h1 && n < 60)
            begin
                mid;
                n++;
            end
            mid;
            mid;
            chk("status", 4'h1 << k, tb_status_o);
            chk("ref_irq", k != 3, irq_o);
            step(1);
            tb_status_clr_i <= 4'hF;
            step(1);
            tb_status_clr_i <= 4'h0;
            mid;
            chk("clear", 1'h0, tb_status_o);
        end
        step(1);
        dec_wr_i <= 1'h1;
        dec_data_i <= 32'h00000064;
        step(1);
        dec_wr_i <= 1'h0;
        mid;
        t0 = decrementer_o;
        step(40);
        mid;
        chk("dec_count", t0 - 64'hA, decrementer_o);
        step(1);
        dec_wr_i <= 1'h1;
        dec_data_i <= 32'h00000002;
        step(1);
        dec_wr_i <= 1'h0;
        watch(30);
        chk("dec_irq", 1'h1, c_irq > 0);
        step(1);
        pit_period_i <= 16'h0003;
        pit_en_i <= 1'h1;
        watch(40);
        chk("pit_irq", 1'h1, c_irq > 0);
        step(1);
        pit_en_i <= 1'h0;
        step(2);
        watch(60);
        chk("pit_off", 1'h0, 64'(c_irq));
        step(1);
        rtc_alarm_i <= rtc_o + 45'h6;
        rtc_alarm_en_i <= 1'h1;
        watch(50);
        chk("rtc_irq", 1'h1, c_irq > 0);
        step(1);
        rtc_alarm_en_i <= 1'h0;
        ext_irq_i <= 4'h4;
        step(3);
        mid;
        chk("ext_irq", 1'h1, irq_o);
        step(1);
        ext_irq_i <= 4'h0;
        step(3);
        mid;
        chk("ext_low", 1'h0, irq_o);
        // first protection write: short period, nmi, all frozen in freeze
        step(1);
        prot_wr_i <= 1'h1;
        prot_wdog_en_i <= 1'h1;
        prot_wdog_period_i <= 16'h0004;
        freeze_indicator_i <= 1'h1;
        step(1);
        prot_wr_i <= 1'h0;
        // the new period reaches the count through a keyed service or at the next expiry
        service_wr_i <= 1'h1;
        service_data_i <= WDOG_KEY1;
        step(1);
        service_data_i <= WDOG_KEY2;
        step(1);
        service_wr_i <= 1'h0;
        mid;
        t0 = time_base_o;
        watch(60);
        chk("tb_frz", t0, time_base_o);
        chk("nmi_frz", 1'h0, 64'(c_nmi));
        step(1);
        freeze_indicator_i <= 1'h0;
        watch(60);
        chk("nmi", 1'h1, c_nmi > 0);
        chk("wrst", 1'h0, 64'(c_rst));
        // a second write must be ignored until reset
        step(1);
        prot_wr_i <= 1'h1;
        prot_wdog_en_i <= 1'h0;
        prot_wdog_rst_sel_i <= 1'h1;
        prot_wdog_period_i <= 16'h0100;
        step(1);
        prot_wr_i <= 1'h0;
        watch(60);
        chk("locked_nmi", 1'h1, c_nmi > 0);
        chk("locked_rst", 1'h0, 64'(c_rst));
        do_reset();
        watch(100);
        chk("wdog_default", 1'h0, 64'(c_nmi + c_rst));
        summarize();
    end
endmodule // system_config_protection_tb
